/* common/rbf_pkg.sv */
// What this block does
// - Format selector 0..7; bit0 prefix, bit1 location, bit2 time stamp.
// - Power-up, clears and default restores set format back to one.
// - Location and stamp are real only with buffer enabled and selected.
// - Buffered locations run from 1 to 1024.
// - Stamp counts milliseconds to 999999.999 s from first stored reading.
// - Converter readings carry location zero and stamp zero.
// - Format change takes effect at the next talk addressing only.
// - Overflowed reading is replaced by the fixed overflow text.
// - Manual trigger fires regardless of mode, not when triggers disabled.
// - Buffer command: disable, linear with length up to 1024, circular.
// - Power-up, clears and default restores disable the buffer.
// - Linear mode stores exactly the length, then keeps contents.
// - Circular mode stores 1024 then wraps, overwriting oldest forever.
// - Converter source sends one reading per talk addressing.
// - Converter source holds off the bus until a fresh reading exists.
// - Full linear buffer stops storing; readings still converted.
// - Single access sends one entry per talk, pointer advances, wraps.
// - Full access sends the whole contents on every talk.
// - Single access holds off until the pointed location is written.
// - Full access on partly filled linear buffer waits for each entry.
// - Full flag sets at programmed length, clears on new linear enable.
// - Half flag sets at length/2 (odd: /2+1) in linear mode only, clears on linear enable.
// - Linear locations ascend from 1, oldest first.
// - Source selects converter, one entry, all entries, maximum, minimum.
// - Full access separates readings with commas.
// - Full access ends with terminator once; other sources after each.
package rbf_pkg;
    // Register byte offsets
    localparam logic [3:0] ADDR_FORMAT  = 4'h0;
    localparam logic [3:0] ADDR_BUFCFG  = 4'h4;
    localparam logic [3:0] ADDR_COMMAND = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'hC;
    // Field positions
    localparam int FMT_LSB    = 0;
    localparam int SRC_LSB    = 4;
    localparam int TRDIS_BIT  = 8;
    localparam int MODE_LSB   = 0;
    localparam int LEN_LSB    = 16;
    localparam int CMD_TRIG   = 0;
    localparam int CMD_CLEAR  = 1;
    localparam int CMD_RESTA  = 2;
    localparam int CMD_RESTB  = 3;
    localparam int ST_FULL    = 0;
    localparam int ST_HALF    = 1;
    localparam int ST_CNT_LSB = 16;
    // Reset values and sizes
    localparam logic [2:0]  FMT_DEFAULT = 3'h1;
    localparam logic [10:0] BUF_DEPTH   = 11'h400;
    localparam logic [29:0] STAMP_MAX   = 30'h3B9A_C9FF;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Timing: one stamp step in microseconds, clock in MHz
    localparam int STAMP_STEP_US = 1000;
    localparam int CLK_MHZ       = 250;
    localparam int MS_CYCLES     = STAMP_STEP_US * CLK_MHZ;

    typedef enum logic [1:0] { BUF_OFF, BUF_LINEAR, BUF_CIRC } buf_mode_e;
    typedef enum logic [2:0] { SRC_CONV, SRC_ONE, SRC_ALL, SRC_MAX, SRC_MIN } src_e;

    // One stored entry
    typedef struct packed {
        logic        ovf;
        logic [31:0] reading;
        logic [29:0] stamp;
    } entry_s;

    // One reading handed to the bus talker
    typedef struct packed {
        logic [2:0]  fmt;
        logic        ovf;
        logic [31:0] reading;
        logic [10:0] location;
        logic [29:0] stamp;
        logic        sep;
        logic        last;
    } out_rec_s;
endpackage

/* verilog/reading_buffer_formatter.sv */
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module reading_buffer_formatter #(
    parameter int MS_CYCLES = rbf_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // AXI4-Lite slave
    input  wire logic [3:0]        s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [3:0]        s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // Converter side
    input  wire logic              conv_valid,
    input  wire logic [31:0]       conv_data,
    input  wire logic              conv_ovf,
    output logic                   meas_trigger,
    // Bus interface side
    input  wire logic              bus_clear,
    input  wire logic              talk_start,
    output rbf_pkg::out_rec_s      out_rec,
    output logic                   out_valid,
    input  wire logic              out_ready
);
    import rbf_pkg::*;

    typedef enum logic { T_IDLE, T_SEND } talk_e;
    localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

    // Register bus state
    logic        aw_ok, next_aw_ok, w_ok, next_w_ok;
    logic [3:0]  wa, next_wa;
    logic [31:0] wd, next_wd;
    logic [3:0]  ws, next_ws;
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic        reg_wr;
    // Control and buffer state
    logic [2:0]  fmt, next_fmt;
    logic [2:0]  src, next_src;
    logic        trig_dis, next_trig_dis;
    buf_mode_e   mode, next_mode;
    logic [10:0] len, next_len;
    logic [10:0] count, next_count;
    logic [9:0]  wr_ptr, next_wr_ptr;
    logic        wrapped, next_wrapped;
    logic        full, next_full, half, next_half;
    logic        t_run, next_t_run;
    logic [17:0] tick, next_tick;
    logic [29:0] ms, next_ms;
    logic [31:0] vmax, next_vmax, vmin, next_vmin;
    logic        next_meas_trigger;
    logic        clr, bcmd, store;
    entry_s      mem [0:1023];
    entry_s      new_entry;
    // Talker state
    talk_e       tstate, next_tstate;
    logic [2:0]  tk_fmt, next_tk_fmt;
    src_e        tk_src, next_tk_src;
    logic [9:0]  rd_ptr, next_rd_ptr;
    logic [10:0] idx, next_idx;
    logic        fresh, next_fresh;
    entry_s      latest, next_latest;
    out_rec_s    next_out_rec;
    logic        next_out_valid;

    // Merge byte lanes of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Field gating by a format value
    function automatic out_rec_s make_rec(input logic [2:0] f, input entry_s e,
                                          input logic [10:0] loc, input logic sep,
                                          input logic last);
        out_rec_s r;
        r.fmt      = f;
        r.ovf      = e.ovf;
        r.reading  = e.ovf ? 32'h0000_0000 : e.reading;
        r.location = f[1] ? loc : 11'h000;
        r.stamp    = f[2] ? e.stamp : 30'h0000_0000;
        r.sep      = sep;
        r.last     = last;
        return r;
    endfunction

    // Bus write strobe and common events
    always_comb begin
        reg_wr = aw_ok && w_ok && !s_bvalid;
        clr    = bus_clear || (reg_wr && wa == ADDR_COMMAND &&
                 (wd[CMD_CLEAR] || wd[CMD_RESTA] || wd[CMD_RESTB]));
        bcmd   = reg_wr && wa == ADDR_BUFCFG && ws[0];
    end

    // Register bus next state
    always_comb begin
        next_aw_ok   = aw_ok;
        next_w_ok    = w_ok;
        next_wa      = wa;
        next_wd      = wd;
        next_ws      = ws;
        next_bvalid  = s_bvalid;
        next_bresp   = s_bresp;
        next_arready = s_arready;
        next_rvalid  = s_rvalid;
        next_rdata   = s_rdata;
        next_rresp   = s_rresp;
        if (s_awvalid && s_awready) begin
            next_aw_ok = 1'b1;
            next_wa    = {s_awaddr[3:2], 2'b00};
        end
        if (s_wvalid && s_wready) begin
            next_w_ok = 1'b1;
            next_wd   = s_wdata;
            next_ws   = s_wstrb;
        end
        if (reg_wr) begin
            next_aw_ok  = 1'b0;
            next_w_ok   = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
        end
        if (s_bvalid && s_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            next_rdata   = 32'h0000_0000;
            case ({s_araddr[3:2], 2'b00})
                ADDR_FORMAT: begin
                    next_rdata[FMT_LSB +: 3] = fmt;
                    next_rdata[SRC_LSB +: 3] = src;
                    next_rdata[TRDIS_BIT]    = trig_dis;
                end
                ADDR_BUFCFG: begin
                    next_rdata[MODE_LSB +: 2] = mode;
                    next_rdata[LEN_LSB +: 11] = len;
                end
                ADDR_STATUS: begin
                    next_rdata[ST_FULL]          = full;
                    next_rdata[ST_HALF]          = half;
                    next_rdata[ST_CNT_LSB +: 11] = count;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (s_rvalid && s_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        next_awready = !next_aw_ok && !next_bvalid;
        next_wready  = !next_w_ok && !next_bvalid;
    end

    // Register bus flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_ok     <= 1'b0;
            w_ok      <= 1'b0;
            wa        <= 4'h0;
            wd        <= 32'h0000_0000;
            ws        <= 4'h0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= RESP_OKAY;
        end else begin
            aw_ok     <= next_aw_ok;
            w_ok      <= next_w_ok;
            wa        <= next_wa;
            wd        <= next_wd;
            ws        <= next_ws;
            s_awready <= next_awready;
            s_wready  <= next_wready;
            s_bvalid  <= next_bvalid;
            s_bresp   <= next_bresp;
            s_arready <= next_arready;
            s_rvalid  <= next_rvalid;
            s_rdata   <= next_rdata;
            s_rresp   <= next_rresp;
        end
    end

    // Control, storage, flags and time stamp next state
    always_comb begin
        logic [31:0] m;
        logic [10:0] l;
        m = 32'h0000_0000;
        l = 11'h000;
        next_fmt      = fmt;
        next_src      = src;
        next_trig_dis = trig_dis;
        next_mode     = mode;
        next_len      = len;
        next_count    = count;
        next_wr_ptr   = wr_ptr;
        next_wrapped  = wrapped;
        next_full     = full;
        next_half     = half;
        next_t_run    = t_run;
        next_tick     = tick;
        next_ms       = ms;
        next_vmax     = vmax;
        next_vmin     = vmin;
        next_meas_trigger = 1'b0;
        // Millisecond time base, saturating at its top value
        if (t_run) begin
            next_tick = (tick == MS_LAST) ? 18'h0_0000 : tick + 18'h0_0001;
            if (tick == MS_LAST && ms != STAMP_MAX) begin
                next_ms = ms + 30'h0000_0001;
            end
        end
        // Storing is gated by mode and linear fill
        store = conv_valid && mode != BUF_OFF &&
                !(mode == BUF_LINEAR && count == len);
        new_entry.ovf     = conv_ovf;
        new_entry.reading = conv_data;
        new_entry.stamp   = t_run ? ms : 30'h0000_0000;
        if (store) begin
            next_t_run  = 1'b1;
            next_wr_ptr = wr_ptr + 10'h001;
            next_wrapped = wrapped || wr_ptr == 10'h3FF;
            if (count != BUF_DEPTH) begin
                next_count = count + 11'h001;
            end
            if ((mode == BUF_LINEAR && count + 11'h001 == len) ||
                (mode == BUF_CIRC && wr_ptr == 10'h3FF)) begin
                next_full = 1'b1;
            end
            if (mode == BUF_LINEAR &&
                count + 11'h001 == (len >> 1) + {10'h000, len[0]}) begin
                next_half = 1'b1;
            end
            if (count == 11'h000 || $signed(conv_data) > $signed(vmax)) begin
                next_vmax = conv_data;
            end
            if (count == 11'h000 || $signed(conv_data) < $signed(vmin)) begin
                next_vmin = conv_data;
            end
        end
        // Register writes
        if (reg_wr && wa == ADDR_FORMAT) begin
            m = merge({23'h00_0000, trig_dis, 1'b0, src, 1'b0, fmt}, wd, ws);
            next_fmt      = m[FMT_LSB +: 3];
            next_src      = (m[SRC_LSB +: 3] > 3'h4) ? 3'h4 : m[SRC_LSB +: 3];
            next_trig_dis = m[TRDIS_BIT];
        end
        if (reg_wr && wa == ADDR_COMMAND && ws[0] && wd[CMD_TRIG] && !trig_dis) begin
            next_meas_trigger = 1'b1;
        end
        if (bcmd) begin
            m = merge({5'h00, len, 14'h0000, mode}, wd, ws);
            l = m[LEN_LSB +: 11];
            case (m[MODE_LSB +: 2])
                2'h1: next_mode = BUF_LINEAR;
                2'h2: next_mode = BUF_CIRC;
                default: next_mode = BUF_OFF;
            endcase
            next_len = (l > BUF_DEPTH) ? BUF_DEPTH :
                       (l == 11'h000) ? 11'h001 : l;
            if (m[MODE_LSB +: 2] == 2'h2) begin
                next_len = BUF_DEPTH;
            end
            next_count   = 11'h000;
            next_wr_ptr  = 10'h000;
            next_wrapped = 1'b0;
            next_full    = 1'b0;
            next_half    = 1'b0;
            next_t_run   = 1'b0;
            next_tick    = 18'h0_0000;
            next_ms      = 30'h0000_0000;
        end
        if (clr) begin
            next_fmt   = FMT_DEFAULT;
            next_src   = SRC_CONV;
            next_mode  = BUF_OFF;
            next_t_run = 1'b0;
        end
    end

    // Control and buffer flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fmt          <= FMT_DEFAULT;
            src          <= SRC_CONV;
            trig_dis     <= 1'b0;
            mode         <= BUF_OFF;
            len          <= BUF_DEPTH;
            count        <= 11'h000;
            wr_ptr       <= 10'h000;
            wrapped      <= 1'b0;
            full         <= 1'b0;
            half         <= 1'b0;
            t_run        <= 1'b0;
            tick         <= 18'h0_0000;
            ms           <= 30'h0000_0000;
            vmax         <= 32'h0000_0000;
            vmin         <= 32'h0000_0000;
            meas_trigger <= 1'b0;
        end else begin
            fmt          <= next_fmt;
            src          <= next_src;
            trig_dis     <= next_trig_dis;
            mode         <= next_mode;
            len          <= next_len;
            count        <= next_count;
            wr_ptr       <= next_wr_ptr;
            wrapped      <= next_wrapped;
            full         <= next_full;
            half         <= next_half;
            t_run        <= next_t_run;
            tick         <= next_tick;
            ms           <= next_ms;
            vmax         <= next_vmax;
            vmin         <= next_vmin;
            meas_trigger <= next_meas_trigger;
        end
    end

    // Reading store
    always_ff @(posedge clk) begin
        if (store) begin
            mem[wr_ptr] <= new_entry;
        end
    end

    // Talker next state
    always_comb begin
        logic        buf_on, sent;
        logic [10:0] total;
        entry_s      e;
        buf_on = mode != BUF_OFF;
        sent   = out_valid && out_ready;
        total  = (mode == BUF_LINEAR) ? len : (wrapped ? BUF_DEPTH : count);
        e      = '0;
        next_tstate    = tstate;
        next_tk_fmt    = tk_fmt;
        next_tk_src    = tk_src;
        next_rd_ptr    = rd_ptr;
        next_idx       = idx;
        next_out_rec   = out_rec;
        next_out_valid = sent ? 1'b0 : out_valid;
        next_fresh     = fresh;
        next_latest    = latest;
        if (conv_valid) begin
            next_fresh  = 1'b1;
            next_latest = '{conv_ovf, conv_data, 30'h0000_0000};
        end
        if (talk_start) begin
            next_tstate    = T_SEND;
            next_tk_fmt    = fmt;
            next_tk_src    = src_e'(src);
            next_idx       = 11'h000;
            next_out_valid = 1'b0;
        end else if (tstate == T_SEND && next_out_valid == 1'b0) begin
            case ((!buf_on && tk_src inside {SRC_ONE, SRC_ALL}) ? SRC_CONV : tk_src)
                SRC_ONE, SRC_ALL: begin
                    if (tk_src == SRC_ONE) begin
                        if ({1'b0, rd_ptr} < count || wrapped) begin
                            e = mem[rd_ptr];
                            next_out_rec   = make_rec(tk_fmt, e, {1'b0, rd_ptr} + 11'h001,
                                                      1'b0, 1'b1);
                            next_out_valid = 1'b1;
                            next_rd_ptr    = ({1'b0, rd_ptr} + 11'h001 >= total) ?
                                             10'h000 : rd_ptr + 10'h001;
                            next_tstate    = T_IDLE;
                        end
                    end else if (idx < count || (wrapped && idx < total)) begin
                        e = mem[idx[9:0]];
                        next_out_rec   = make_rec(tk_fmt, e, idx + 11'h001,
                                                  idx != 11'h000,
                                                  idx + 11'h001 == total);
                        next_out_valid = 1'b1;
                        next_idx       = idx + 11'h001;
                        if (idx + 11'h001 == total) begin
                            next_tstate = T_IDLE;
                        end
                    end
                end
                SRC_MAX, SRC_MIN: begin
                    if (count != 11'h000) begin
                        e.reading      = (tk_src == SRC_MAX) ? vmax : vmin;
                        next_out_rec   = make_rec(tk_fmt, e, 11'h000, 1'b0, 1'b1);
                        next_out_valid = 1'b1;
                        next_tstate    = T_IDLE;
                    end
                end
                default: begin
                    if (fresh && !conv_valid) begin
                        next_out_rec   = make_rec(tk_fmt, latest, 11'h000, 1'b0, 1'b1);
                        next_out_valid = 1'b1;
                        next_fresh     = 1'b0;
                        next_tstate    = T_IDLE;
                    end
                end
            endcase
        end
        if (clr || bcmd) begin
            next_rd_ptr = 10'h000;
        end
        if (clr) begin
            next_tstate    = T_IDLE;
            next_out_valid = 1'b0;
        end
    end

    // Talker flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tstate    <= T_IDLE;
            tk_fmt    <= FMT_DEFAULT;
            tk_src    <= SRC_CONV;
            rd_ptr    <= 10'h000;
            idx       <= 11'h000;
            fresh     <= 1'b0;
            latest    <= '0;
            out_rec   <= '0;
            out_valid <= 1'b0;
        end else begin
            tstate    <= next_tstate;
            tk_fmt    <= next_tk_fmt;
            tk_src    <= next_tk_src;
            rd_ptr    <= next_rd_ptr;
            idx       <= next_idx;
            fresh     <= next_fresh;
            latest    <= next_latest;
            out_rec   <= next_out_rec;
            out_valid <= next_out_valid;
        end
    end
endmodule

/* verification/rbf_checker.sv */
`timescale 1ns/1ps
module rbf_checker
    import rbf_pkg::*;
#(parameter int MS_CYCLES = 4) (
    // Watched ports
    input wire logic     clk, rst_n, out_valid, out_ready, meas_trigger,
    input wire logic     s_arvalid, s_arready, s_rvalid, s_rready, talk_start, bus_clear,
    input wire out_rec_s out_rec
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_rec_hold: assert property (out_valid && !out_ready && !talk_start && !bus_clear
        |=> out_valid && $stable(out_rec)) else $error("record changed while stalled");
    chk_loc_range: assert property (out_valid |-> out_rec.location <= 11'h400)
        else $error("location above range");
    chk_loc_fmt: assert property (out_valid && !out_rec.fmt[1] |-> out_rec.location == 0)
        else $error("location sent unasked");
    chk_stamp_fmt: assert property (out_valid && !out_rec.fmt[2] |-> out_rec.stamp == 0)
        else $error("stamp sent unasked");
    chk_stamp_max: assert property (out_valid |-> out_rec.stamp <= STAMP_MAX)
        else $error("stamp above range");
    chk_ovf_text: assert property (out_valid && out_rec.ovf |-> out_rec.reading == 0)
        else $error("overflow reading not blanked");
    chk_trig_pulse: assert property (meas_trigger |=> !meas_trigger)
        else $error("trigger longer than a pulse");
    chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
        else $error("read not answered");
    cover property (out_valid && out_ready && out_rec.sep);
    cover property (out_valid && out_ready && out_rec.ovf);
    cover property (meas_trigger);
endmodule
bind reading_buffer_formatter rbf_checker #(.MS_CYCLES(MS_CYCLES)) rbf_checker_inst (
    .clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_ready(out_ready),
    .meas_trigger(meas_trigger), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .out_rec(out_rec), .talk_start(talk_start),
    .bus_clear(bus_clear));

/* verification/talk_controller_model.sv */
`timescale 1ns/1ps
module talk_controller_model (
    input wire logic              clk, out_valid,
    input wire rbf_pkg::out_rec_s out_rec,
    output logic                  talk_start, out_ready
);
    import rbf_pkg::*;
    out_rec_s got[$];
    initial talk_start = 1'b0;
    initial out_ready = 1'b0;
    // Accept records with random stalls
    always @(posedge clk) begin
        out_ready <= 1'($urandom_range(0, 1));
        if (out_valid && out_ready) got.push_back(out_rec);
    end
    // Address to talk, then wait for n records
    task automatic talk(input int n);
        @(posedge clk) talk_start <= 1'b1;
        @(posedge clk) talk_start <= 1'b0;
        while (got.size() < n) @(posedge clk);
    endtask
endmodule

/* verification/test_reading_buffer_formatter.sv */
`timescale 1ns/1ps
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_reading_buffer_formatter;
    import rbf_pkg::*;
    logic       clk, rst_n, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
    logic       cv, covf, clr, trig, talk, ordy, ovalid;
    logic [1:0] bresp, rresp;
    logic [3:0] awa, ara;
    logic [31:0] wd, rdat, cd, r;
    logic [31:0] v[4];
    out_rec_s   orec;
    int         n_mismatch = 0, n_compared = 0, ntrig = 0;
    reading_buffer_formatter #(.MS_CYCLES(4)) reading_buffer_formatter_inst (
        .clk(clk), .rst_n(rst_n), .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr),
        .s_wdata(wd), .s_wstrb(4'hf), .s_wvalid(wv), .s_wready(wrdy), .s_bresp(bresp),
        .s_bvalid(bv), .s_bready(brdy), .s_araddr(ara), .s_arvalid(arv), .s_arready(arr),
        .s_rdata(rdat), .s_rresp(rresp), .s_rvalid(rv), .s_rready(rrdy), .conv_valid(cv),
        .conv_data(cd), .conv_ovf(covf), .meas_trigger(trig), .bus_clear(clr),
        .talk_start(talk), .out_rec(orec), .out_valid(ovalid), .out_ready(ordy));
    talk_controller_model tc (.clk(clk), .out_valid(ovalid), .out_rec(orec),
        .talk_start(talk), .out_ready(ordy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (trig) ntrig++;
    // Register write, each channel released when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) {awa, wd, awv, wv, brdy} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        brdy <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk) {ara, arv, rrdy} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        r = rdat;
        rrdy <= 1'b0;
    endtask
    task automatic conv(input logic [31:0] d, input logic o);
        @(posedge clk) {cd, covf, cv} <= {d, o, 1'b1};
        @(posedge clk) cv <= 1'b0;
    endtask
    function automatic logic [10:0] exp_loc(input logic [2:0] f, input int i);
        return f[1] ? 11'(i) : 11'h000;
    endfunction
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {rst_n, awv, wv, brdy, arv, rrdy, cv, covf, clr, awa, ara, wd, cd} = '0;
        void'($urandom(6));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_FORMAT);
        `CMP("format", 7'h01, r[6:0])
        for (int f = 0; f < 8; f++) begin
            wr(ADDR_FORMAT, 32'(f));
            v[0] = $urandom;
            tc.got.delete();
            fork
                tc.talk(1);
                begin
                    repeat (10) @(posedge clk);
                    `CMP("held", 0, tc.got.size())
                    conv(v[0], f == 7);
                end
            join
            `CMP("cloc", 11'h000, tc.got[0].location)
            `CMP("cstamp", 30'h0, tc.got[0].stamp)
            `CMP("crd", f == 7 ? 32'h0 : v[0], tc.got[0].reading)
            `CMP("cfmt", 3'(f), tc.got[0].fmt)
            `CMP("clast", 1'b1, tc.got[0].last)
        end
        $display("converter test done");
        wr(ADDR_BUFCFG, 32'h0003_0001);
        wr(ADDR_FORMAT, 32'h0000_0027);
        for (int i = 0; i < 4; i++) begin
            v[i] = $urandom;
            conv(v[i], 1'b0);
            if (i == 1) rd(ADDR_STATUS);
            if (i == 1) `CMP("half", 32'h0002_0002, r)
        end
        rd(ADDR_STATUS);
        `CMP("full", 32'h0003_0003, r)
        for (int t = 0; t < 2; t++) begin
            tc.got.delete();
            tc.talk(3);
            for (int i = 0; i < 3; i++) begin
                `CMP("brd", v[i], tc.got[i].reading)
                `CMP("bloc", exp_loc(3'h7, i + 1), tc.got[i].location)
                `CMP("sep", i != 0, tc.got[i].sep)
                `CMP("last", i == 2, tc.got[i].last)
            end
        end
        `CMP("stamp0", 30'h0, tc.got[0].stamp)
        wr(ADDR_FORMAT, 32'h0000_0013);
        for (int i = 0; i < 4; i++) begin
            tc.got.delete();
            tc.talk(1);
            `CMP("one", exp_loc(3'h3, i % 3 + 1), tc.got[0].location)
        end
        $display("buffer test done");
        wr(ADDR_COMMAND, 32'h0000_0001);
        wr(ADDR_FORMAT, 32'h0000_0100);
        wr(ADDR_COMMAND, 32'h0000_0001);
        `CMP("trig", 1, ntrig)
        for (int c = 1; c < 5; c++) begin
            wr(ADDR_BUFCFG, 32'h0000_0002);
            wr(ADDR_FORMAT, 32'h0000_0027);
            if (c < 4) wr(ADDR_COMMAND, 32'h1 << c);
            else {clr} <= 1'b1;
            @(posedge clk) clr <= 1'b0;
            rd(ADDR_FORMAT);
            `CMP("dflt", 7'h01, r[6:0])
            rd(ADDR_BUFCFG);
            `CMP("off", 2'h0, r[1:0])
        end
        $display("default test done");
        report_and_stop();
    end
endmodule
